// ---- rtl/aws_top.sv ----
module aws_top
#(
    parameter logic [7:0] CMD_LAST = aws_pkg::CMD_LAST_VALID
)
(
    input  wire logic                   core_clk,
    input  wire logic                   rst_b,
    input  wire aws_pkg::aws_bus_req_s  bus_req,
    output logic [31:0]                 rd_data,
    input  wire logic signed [31:0]     following_error,
    input  wire aws_pkg::aws_drive_s    drive,
    input  wire aws_pkg::aws_param_chk_s param_chk,
    input  wire logic                   ot_disable,
    input  wire logic                   ot_pos_pin,
    input  wire logic                   ot_neg_pin,
    output logic [31:0]                 warning_word,
    output logic                        servo_on_cmd,
    output logic [15:0]                 motion_cmd_code
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (CMD_LAST == 8'h00)
    begin : g_bad_cmd
        $error("aws_top needs at least two usable command codes");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] warn_ff;
    logic [31:0] nxt_warn;
    logic [15:0] orp_num_ff;
    logic [15:0] nxt_orp_num;
    logic [15:0] drv_code_ff;
    logic [15:0] nxt_drv_code;
    logic [15:0] run_cmd_ff;
    logic [15:0] nxt_run_cmd;
    logic [15:0] mode_one_ff;
    logic [15:0] nxt_mode_one;
    logic [15:0] cmd_ff;
    logic [15:0] nxt_cmd;
    logic [31:0] thr_ff;
    logic [31:0] nxt_thr;
    logic [31:0] rd_data_ff;
    logic [31:0] nxt_rd_data;
    logic [1:0]  ot_sync;
    logic [31:0] abs_err;
    logic        dev_over;
    logic        cmd_bad;
    logic [7:0]  bus_idx;
    logic        bus_aligned;

    // ------------------------------------------------------------
    // overtravel pins come from outside, so synchronise them
    // ------------------------------------------------------------
    aws_sync #(
        .WIDTH    (2)
    ) u_ot_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in ({ot_neg_pin, ot_pos_pin}),
        .sync_out (ot_sync)
    );

    // ------------------------------------------------------------
    // condition detection
    // ------------------------------------------------------------
    // magnitude compare; the most negative value keeps its bit pattern, which is its exact magnitude as unsigned
    always_comb
    begin
        abs_err  = following_error[31] ? (32'h0000_0000 - following_error) : following_error;
        dev_over = (abs_err > thr_ff); // RULE1
        cmd_bad  = (cmd_ff[15:8] != 8'h00) || (cmd_ff[7:0] > CMD_LAST); // RULE6
    end

    // warning word rebuilt every cycle, so clear conditions fall away
    always_comb
    begin
        nxt_warn = 32'h0000_0000; // RULE11
        nxt_warn[aws_pkg::BIT_DEV_WARN] = dev_over
            && mode_one_ff[aws_pkg::MODE_DEV_LEVEL_BIT]; // RULE1
        nxt_warn[aws_pkg::BIT_SET_PARAM] = param_chk.set_bad; // RULE2
        nxt_warn[aws_pkg::BIT_FIX_PARAM] = param_chk.fix_bad; // RULE4
        nxt_warn[aws_pkg::BIT_DRIVE_WARN] = drive.warn; // RULE5
        nxt_warn[aws_pkg::BIT_CMD_ERR] = cmd_bad; // RULE6
        nxt_warn[aws_pkg::BIT_OT_POS] = ot_disable && ot_sync[0]; // RULE7
        nxt_warn[aws_pkg::BIT_OT_NEG] = ot_disable && ot_sync[1]; // RULE7
        nxt_warn[aws_pkg::BIT_SERVO_NOT_ON] = run_cmd_ff[aws_pkg::RUN_SERVO_ON_BIT]
            && !drive.servo_on; // RULE8
        nxt_warn[aws_pkg::BIT_COMM_ERR] = drive.comm_err; // RULE9
    end

    // parameter number: setting errors take priority, last value held
    always_comb
    begin
        nxt_orp_num = orp_num_ff;
        if (param_chk.set_bad)
        begin
            nxt_orp_num = {6'h00, param_chk.set_num}; // RULE3 RULE10
        end
        else if (param_chk.fix_bad)
        begin
            nxt_orp_num = {6'h00, param_chk.fix_num} + aws_pkg::FIXED_NUM_OFFSET; // RULE4 RULE10
        end
        nxt_drv_code = drive.warn ? drive.warn_code : drv_code_ff; // RULE5
    end

    // ------------------------------------------------------------
    // register bus slave
    // ------------------------------------------------------------
    assign bus_idx     = bus_req.addr[9:2];
    assign bus_aligned = (bus_req.addr[1:0] == 2'b00);

    // writes; read-only indices ignore writes
    always_comb
    begin
        nxt_run_cmd  = run_cmd_ff;
        nxt_mode_one = mode_one_ff;
        nxt_cmd      = cmd_ff;
        nxt_thr      = thr_ff;
        if (bus_req.wr && bus_aligned)
        begin
            unique case (bus_idx)
                aws_pkg::IDX_RUN_COMMAND:   nxt_run_cmd  = bus_req.wdata[15:0];
                aws_pkg::IDX_MODE_ONE:      nxt_mode_one = bus_req.wdata[15:0];
                aws_pkg::IDX_MOTION_CMD:    nxt_cmd      = bus_req.wdata[15:0];
                aws_pkg::IDX_DEV_THRESHOLD: nxt_thr      = bus_req.wdata;
                default:                    nxt_thr      = thr_ff;
            endcase
        end
    end

    // read data stand only in the cycle after the strobe
    always_comb
    begin
        nxt_rd_data = 32'h0000_0000;
        if (bus_req.rd && bus_aligned)
        begin
            unique case (bus_idx)
                aws_pkg::IDX_WARNING_WORD:   nxt_rd_data = warn_ff;
                aws_pkg::IDX_OVER_RANGE_NUM: nxt_rd_data = {16'h0000, orp_num_ff};
                aws_pkg::IDX_DRIVE_CODE:     nxt_rd_data = {16'h0000, drv_code_ff};
                aws_pkg::IDX_RUN_COMMAND:    nxt_rd_data = {16'h0000, run_cmd_ff};
                aws_pkg::IDX_MODE_ONE:       nxt_rd_data = {16'h0000, mode_one_ff};
                aws_pkg::IDX_MOTION_CMD:     nxt_rd_data = {16'h0000, cmd_ff};
                aws_pkg::IDX_DEV_THRESHOLD:  nxt_rd_data = thr_ff;
                default:                     nxt_rd_data = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            warn_ff     <= aws_pkg::RST_WORD32;
            orp_num_ff  <= aws_pkg::RST_WORD16;
            drv_code_ff <= aws_pkg::RST_WORD16;
            run_cmd_ff  <= aws_pkg::RST_WORD16;
            mode_one_ff <= aws_pkg::RST_WORD16;
            cmd_ff      <= aws_pkg::RST_WORD16;
            thr_ff      <= aws_pkg::RST_THRESHOLD;
            rd_data_ff  <= aws_pkg::RST_WORD32;
        end
        else
        begin
            warn_ff     <= nxt_warn;
            orp_num_ff  <= nxt_orp_num;
            drv_code_ff <= nxt_drv_code;
            run_cmd_ff  <= nxt_run_cmd;
            mode_one_ff <= nxt_mode_one;
            cmd_ff      <= nxt_cmd;
            thr_ff      <= nxt_thr;
            rd_data_ff  <= nxt_rd_data;
        end
    end

    assign rd_data         = rd_data_ff;
    assign warning_word    = warn_ff;
    assign servo_on_cmd    = run_cmd_ff[aws_pkg::RUN_SERVO_ON_BIT];
    assign motion_cmd_code = cmd_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_dev_warn_set: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE1
        (dev_over && mode_one_ff[aws_pkg::MODE_DEV_LEVEL_BIT]) |=> warn_ff[0])
        else $error("deviation warning missing");

    a_dev_alarm_mode: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE1
        !mode_one_ff[aws_pkg::MODE_DEV_LEVEL_BIT] |=> !warn_ff[0])
        else $error("deviation warning set in alarm mode");

    a_set_param_bit: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE2
        ##1 warn_ff[1] == $past(param_chk.set_bad))
        else $error("setting error bit wrong");

    a_set_param_num: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE3
        param_chk.set_bad |=> orp_num_ff == {6'h00, $past(param_chk.set_num)})
        else $error("setting parameter number wrong");

    a_fix_param_num: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE4
        (param_chk.fix_bad && !param_chk.set_bad) |=>
        (warn_ff[2] && orp_num_ff == {6'h00, $past(param_chk.fix_num)} + 16'h03E8))
        else $error("fixed parameter number wrong");

    a_drive_warn: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE5
        drive.warn |=> (warn_ff[3] && drv_code_ff == $past(drive.warn_code)))
        else $error("drive warning not captured");

    a_cmd_error: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE6
        (bus_req.wr && bus_req.addr == 10'h120 && bus_req.wdata[15:0] > 16'h0028)
        |=> ##1 warn_ff[4])
        else $error("bad command not flagged");

    a_ot_pos_pin: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE7
        (ot_disable && ot_sync[0]) |=> warn_ff[6])
        else $error("positive overtravel bit missing");

    a_ot_enabled: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE7
        !ot_disable |=> (!warn_ff[6] && !warn_ff[7]))
        else $error("overtravel bits set while handled");

    a_servo_not_on: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE8
        (servo_on_cmd && !drive.servo_on) |=> warn_ff[8])
        else $error("servo not on bit missing");

    a_comm_recover: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE9
        (drive.comm_err ##1 !drive.comm_err) |=> !warn_ff[9])
        else $error("link error bit did not clear");

    a_unused_zero: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE11
        (warn_ff[5] == 1'b0) && (warn_ff[31:10] == 22'h000000))
        else $error("unassigned warning bit set");

    a_read_warn: assert property (@(posedge core_clk) disable iff (!rst_b)
        (bus_req.rd && bus_req.addr == 10'h008) |=> rd_data == $past(warn_ff))
        else $error("warning read data wrong");

endmodule : aws_top

// ---- inc/aws_pkg.sv ----
// Overview of operation
// RULE1: deviation over threshold sets bit 0 if warning
// RULE2: bit 1 follows any setting parameter out of range
// RULE3: out-of-range setting number goes to number register
// RULE4: bit 2 follows fixed error, number recorded
// RULE5: bit 3 follows drive warning, code readable
// RULE6: bit 4 set while command code unusable
// RULE7: overtravel inputs set bits 6, 7 when disabled
// RULE8: bit 8 when servo-on asked but not reached
// RULE9: bit 9 follows link error, clears itself
// RULE10: setting numbers plain, fixed numbers plus 1000
// RULE11: unassigned warning bits always read zero
package aws_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0]  IDX_OVER_RANGE_NUM  = 8'h01;
    localparam logic [7:0]  IDX_WARNING_WORD    = 8'h02;
    localparam logic [7:0]  IDX_DRIVE_CODE      = 8'h2D;
    localparam logic [7:0]  IDX_RUN_COMMAND     = 8'h40;
    localparam logic [7:0]  IDX_MODE_ONE        = 8'h41;
    localparam logic [7:0]  IDX_MOTION_CMD      = 8'h48;
    localparam logic [7:0]  IDX_DEV_THRESHOLD   = 8'h62;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int          BIT_DEV_WARN        = 0;
    localparam int          BIT_SET_PARAM       = 1;
    localparam int          BIT_FIX_PARAM       = 2;
    localparam int          BIT_DRIVE_WARN      = 3;
    localparam int          BIT_CMD_ERR         = 4;
    localparam int          BIT_OT_POS          = 6;
    localparam int          BIT_OT_NEG          = 7;
    localparam int          BIT_SERVO_NOT_ON    = 8;
    localparam int          BIT_COMM_ERR        = 9;
    localparam int          RUN_SERVO_ON_BIT    = 0;
    localparam int          MODE_DEV_LEVEL_BIT  = 8;

    // ------------------------------------------------------------
    // reset values and encodings
    // ------------------------------------------------------------
    localparam logic [15:0] RST_WORD16          = 16'h0000;
    localparam logic [31:0] RST_WORD32          = 32'h0000_0000;
    localparam logic [31:0] RST_THRESHOLD       = 32'h7FFF_FFFF;
    localparam logic [15:0] FIXED_NUM_OFFSET    = 16'h03E8;
    localparam logic [7:0]  CMD_LAST_VALID      = 8'h28;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [9:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } aws_bus_req_s;

    typedef struct packed {
        logic        warn;
        logic [15:0] warn_code;
        logic        servo_on;
        logic        comm_err;
    } aws_drive_s;

    typedef struct packed {
        logic        set_bad;
        logic [9:0]  set_num;
        logic        fix_bad;
        logic [9:0]  fix_num;
    } aws_param_chk_s;

endpackage : aws_pkg

// ---- rtl/aws_sync.sv ----
module aws_sync
#(
    parameter int WIDTH = 2
)
(
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (WIDTH < 1)
    begin : g_bad_width
        $error("aws_sync needs at least one bit");
    end

    // ------------------------------------------------------------
    // two-stage synchroniser per bit
    // ------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        logic meta_ff;
        logic sync_ff;
        logic nxt_meta;
        logic nxt_sync;

        // first stage feeds only the second stage
        always_comb
        begin
            nxt_meta = async_in[i];
            nxt_sync = meta_ff;
        end

        always_ff @(posedge core_clk)
        begin
            if (!rst_b)
            begin
                meta_ff <= 1'b0;
                sync_ff <= 1'b0;
            end
            else
            begin
                meta_ff <= nxt_meta;
                sync_ff <= nxt_sync;
            end
        end

        assign sync_out[i] = sync_ff;
    end

endmodule : aws_sync

// ---- bench/aws_drive_model.sv ----
module aws_drive_model
(
    input  wire logic           core_clk,
    input  wire logic           rst_b,
    input  wire logic           servo_on_cmd,
    input  wire logic           warn_in,
    input  wire logic [15:0]    code_in,
    input  wire logic           comm_in,
    input  wire logic           refuse,
    input  wire logic           slow,
    output aws_pkg::aws_drive_s drive
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] wait_ff;
    logic       on_ff;

    // ------------------------------------------------------------
    // servo-on reached a short or long time after the command
    // ------------------------------------------------------------
    // refuse models a drive that never gets there
    always_ff @(posedge core_clk)
    begin
        if (!rst_b || !servo_on_cmd || refuse)
        begin
            wait_ff <= 4'h0;
            on_ff   <= 1'b0;
        end
        else if (wait_ff == (slow ? 4'h9 : 4'h1))
            on_ff <= 1'b1;
        else
            wait_ff <= wait_ff + 4'h1;
    end

    // code lines are not held once the warning drops: inverse so a stale copy cannot pass
    assign drive = '{warn: warn_in, warn_code: warn_in ? code_in : ~code_in,
                     servo_on: on_ff, comm_err: comm_in};
endmodule : aws_drive_model

// ---- bench/axis_warning_status_test.sv ----
module axis_warning_status_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic                    core_clk = 1'b0;
    logic                    rst_b = 1'b0;
    aws_pkg::aws_bus_req_s   bus_req = '0;
    logic [31:0]             rd_data;
    logic [31:0]             warning_word;
    logic                    servo_on_cmd;
    logic [15:0]             motion_cmd_code;
    logic signed [31:0]      fe = '0;
    aws_pkg::aws_drive_s     drive;
    aws_pkg::aws_param_chk_s pc = '0;
    logic                    ot_dis = 1'b0;
    logic                    ot_p = 1'b0;
    logic                    ot_n = 1'b0;
    logic                    warn_in = 1'b0;
    logic                    comm_in = 1'b0;
    logic                    refuse = 1'b0;
    logic                    slow = 1'b0;
    logic [15:0]             code_in = '0;
    int                      fails = 0;
    int                      samples_checked = 0;
    logic [31:0]             r = 32'h4080;
    logic [31:0]             thr, mode, cmdw, run, d, exp_num, exp_code;
    logic [9:0]              addrs [9] = '{10'h008, 10'h004, 10'h0B4, 10'h100, 10'h104,
                                           10'h120, 10'h188, 10'h3FC, 10'h009};

    always #25 core_clk = ~core_clk;

    aws_top DUT (.core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
                 .following_error(fe), .drive(drive), .param_chk(pc), .ot_disable(ot_dis),
                 .ot_pos_pin(ot_p), .ot_neg_pin(ot_n), .warning_word(warning_word),
                 .servo_on_cmd(servo_on_cmd), .motion_cmd_code(motion_cmd_code));

    aws_drive_model drv (.core_clk(core_clk), .rst_b(rst_b), .servo_on_cmd(servo_on_cmd),
                         .warn_in(warn_in), .code_in(code_in), .comm_in(comm_in),
                         .refuse(refuse), .slow(slow), .drive(drive));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // reference warning word from the condition levels held in the bench
    function automatic logic [31:0] exp_warn();
        logic [31:0] w;
        int          a;
        a = (fe < 0) ? -fe : fe;
        w = '0;
        w[0] = mode[8] && (a > int'(thr));
        w[1] = pc.set_bad;
        w[2] = pc.fix_bad;
        w[3] = warn_in;
        w[4] = cmdw[15:0] > {8'h00, aws_pkg::CMD_LAST_VALID};
        w[6] = ot_dis & ot_p;
        w[7] = ot_dis & ot_n;
        w[8] = run[0] & refuse;
        w[9] = comm_in;
        return w;
    endfunction : exp_warn

    // one gap cycle after each access so no strobe is assigned twice in a step
    task automatic bus_wr(input logic [9:0] a, input logic [31:0] v);
        @(posedge core_clk) bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk) bus_req <= '0;
    endtask : bus_wr

    task automatic bus_rd(input logic [9:0] a, output logic [31:0] v);
        @(posedge core_clk) bus_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk) bus_req <= '0;
        @(posedge core_clk) v = rd_data;
    endtask : bus_rd

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        bus_wr(10'h008, 32'hFFFF_FFFF);
        bus_wr(10'h004, 32'hFFFF_FFFF);
        bus_wr(10'h3FC, 32'hFFFF_FFFF);
        // reset values, read-only places, unmapped and misaligned reads
        foreach (addrs[i])
        begin
            bus_rd(addrs[i], d);
            chk("reset read", (i == 6) ? 32'h7FFF_FFFF : 32'h0, d);
        end
        exp_num = '0;
        exp_code = '0;
        repeat (60)
        begin
            r = lfsr(r);
            thr = {16'h0, r[31:16]};
            mode = {23'h0, r[4], 8'h0};
            run = {31'h0, r[5]};
            cmdw = {r[15:8], r[12], r[13:6] & 8'h01, 2'h0, r[11:6]};
            bus_wr(10'h188, thr);
            bus_wr(10'h104, mode);
            bus_wr(10'h120, cmdw);
            bus_wr(10'h100, run);
            cmdw = {16'h0, cmdw[15:0]};
            r = lfsr(r);
            @(posedge core_clk);
            fe <= {{16{r[15]}}, r[15:0]};
            pc <= '{set_bad: r[16], set_num: 10'(r[31:20] % 1000), fix_bad: r[17],
                    fix_num: 10'(r[29:18] % 1000)};
            {ot_dis, ot_p, ot_n, warn_in, comm_in, refuse, slow} <= r[24:18];
            code_in <= r[31:16];
            @(posedge core_clk);
            if (r[25])
            begin
                thr = (fe < 0) ? -fe : fe;
                bus_wr(10'h188, thr);
            end
            repeat (14) @(posedge core_clk);
            if (pc.set_bad)
                exp_num = {22'h0, pc.set_num};
            else if (pc.fix_bad)
                exp_num = {22'h0, pc.fix_num} + 32'd1000;
            if (warn_in)
                exp_code = {16'h0, code_in};
            bus_rd(10'h008, d);
            chk("warning read", exp_warn(), d);
            chk("warning_word", exp_warn(), warning_word);
            bus_rd(10'h004, d);
            chk("over-range number", exp_num, d);
            bus_rd(10'h0B4, d);
            chk("drive code", exp_code, d);
            chk("servo_on_cmd", run, {31'h0, servo_on_cmd});
            chk("motion_cmd_code", cmdw, {16'h0, motion_cmd_code});
        end
        results();
    end

    // hang guard: about ten times the expected run
    initial
    begin
        #(20000 * 50);
        fails++;
        results();
    end
endmodule : axis_warning_status_test
